/* File: shared/ssfd_defines.vh */
`ifndef SSFD_DEFINES_VH
`define SSFD_DEFINES_VH

// transfer mode field encoding for full-duplex operation
`define SSFD_MODE_TXRX     2'b10
// bit order select: 1 sends and receives msb first
`define SSFD_MSB_FIRST     1'b1
// core clock period and internal serial clock period
`define SSFD_CLK_NS        8
`define SSFD_SCK_PERIOD_NS 80
`define SSFD_SCK_HALF_CYC  ((`SSFD_SCK_PERIOD_NS / `SSFD_CLK_NS) / 2)
// frame length: last bit index
`define SSFD_LAST_BIT      3'h7
`define SSFD_CNT_ZERO      3'h0
`define SSFD_CNT_ONE       3'h1
// reset and initial values
`define SSFD_TXE_INIT      1'b1
`define SSFD_RXF_INIT      1'b0
`define SSFD_BUF_INIT      8'h00
`define SSFD_IDLE_LVL      1'b1

`endif

/* File: hdl/ssfd_sync2.v */
`timescale 1ns/1ns
`default_nettype none

// two-stage synchroniser for levels entering the core clock domain
module ssfd_sync2 #(
    parameter             WIDTH   = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] d_in,
    output wire [WIDTH-1:0] q_out
);

    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    always @(posedge clk) begin
        if (rst) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else begin
            meta_reg <= d_in;
            sync_reg <= meta_reg;
        end
    end

    assign q_out = sync_reg;

endmodule // ssfd_sync2

`default_nettype wire

/* File: hdl/ssfd_sckgen.v */
`timescale 1ns/1ns
`default_nettype none

// internal serial clock: idles high, a low phase completes unless reset cuts it short
module ssfd_sckgen #(
    parameter HALF = 5,
    parameter CW   = 8
) (
    input  wire clk,
    input  wire rst,
    input  wire run,
    output wire sck,
    output wire fall_pls,
    output wire rise_pls
);

    localparam [CW-1:0] HALF_M1 = HALF - 1;
    localparam [CW-1:0] CNT_ONE = 1;

    reg [CW-1:0] cnt_reg;
    reg          sck_reg;
    reg          fall_reg;
    reg          rise_reg;

    always @(posedge clk) begin
        if (rst) begin
            cnt_reg  <= {CW{1'b0}};
            sck_reg  <= 1'b1;
            fall_reg <= 1'b0;
            rise_reg <= 1'b0;
        end else begin
            fall_reg <= 1'b0;
            rise_reg <= 1'b0;
            if (!sck_reg || run) begin
                if (cnt_reg == HALF_M1) begin
                    cnt_reg  <= {CW{1'b0}};
                    sck_reg  <= ~sck_reg;
                    fall_reg <= sck_reg;
                    rise_reg <= ~sck_reg;
                end else begin
                    cnt_reg <= cnt_reg + CNT_ONE;
                end
            end else begin
                // auto wait: clock parked high
                cnt_reg <= {CW{1'b0}};
            end
        end
    end

    assign sck      = sck_reg;
    assign fall_pls = fall_reg;
    assign rise_pls = rise_reg;

endmodule // ssfd_sckgen

`default_nettype wire

/* File: hdl/ssfd_serial.v */
// Operation
// R1: mode 10 selects full duplex; clock, order
// R2: tx write clears empty; rx read clears full
// R3: start bit sets active at falling edge
// R4: drive on falling, sample on rising edges
// R5: shift flag high first to eighth fall
// R6: empty flag set at rise after load
// R7: eighth bit: copy, full flag, interrupt together
// R8: internal clock loads within one period
// R9: external first fall loads, rise receives
// R10: internal clock waits high until both accesses
// R11: wait released by both accesses, any order
// R12: external clock: software services buffers first
// R13: empty at shift start sets underrun flag
// R14: underrun holds serial out high
// R15: software reads buffer then forces stop
// R16: unread full buffer at end: overrun
// R17: overrun ignores newly received bits
// R18: reads give old frame then shift register
// R19: external: eight more clocks then stop
// R20: start cleared: finish frame, stop, out high
// R21: external: clear start before next frame
// R22: forced stop halts and initializes everything
// R23: no interrupts while overrun stays uncorrected
`timescale 1ns/1ns
`default_nettype none
`include "ssfd_defines.vh"

module ssfd_serial #(
    parameter SCK_HALF = `SSFD_SCK_HALF_CYC
) (
    input  wire       core_clk,
    input  wire       sys_rst,
    input  wire [1:0] transfer_mode_field,
    input  wire       clk_src_ext,
    input  wire       bit_order_select,
    input  wire       start_set,
    input  wire       start_clr,
    input  wire       forced_stop_bit,
    input  wire       tx_wr_stb,
    input  wire [7:0] tx_wr_data,
    input  wire       rx_rd_stb,
    input  wire       rx_overrun_clr,
    input  wire       sck_in,
    input  wire       si_in,
    output wire       transfer_start_bit,
    output wire       transfer_active_flag,
    output wire       shift_active_flag,
    output wire       tx_buffer_empty_flag,
    output wire       rx_buffer_full_flag,
    output wire       tx_underrun_flag,
    output wire       rx_overrun_flag,
    output wire       serial_irq,
    output wire [7:0] rx_rd_data,
    output wire       sck_out,
    output wire       sck_oe,
    output wire       so_out
);

    reg       start_reg;
    reg       active_reg;
    reg       sef_reg;
    reg       txe_reg;
    reg       rxf_reg;
    reg       tx_underrun_flag_reg;
    reg       rx_overrun_flag_reg;
    reg       irq_reg;
    reg [7:0] rd_data_reg;
    reg       sck_oe_reg;
    reg       so_reg;
    reg [7:0] tx_buf_reg;
    reg [7:0] rx_buf_reg;
    reg [7:0] shift_reg;
    reg [2:0] fall_cnt_reg;
    reg [2:0] rise_cnt_reg;
    reg       in_frame_reg;
    reg       load_pend_reg;
    reg       rd_seen_reg;
    reg       sck_d_reg;

    wire       sck_s;
    wire       si_s;
    wire       int_sck;
    wire       int_fall;
    wire       int_rise;
    wire       mode_ok;
    wire       ext_fall;
    wire       ext_rise;
    wire       fall_ev;
    wire       rise_ev;
    wire       int_run;
    wire       msb;
    wire [7:0] shift_nx;
    wire       frame_start;
    wire       frame_end;
    wire       txe_set;
    wire       rxf_set;
    wire       ovr_set;

    ssfd_sync2 #(
        .WIDTH   (2),
        .RST_VAL (2'h3)
    ) u_sync (
        .clk   (core_clk),
        .rst   (sys_rst),
        .d_in  ({sck_in, si_in}),
        .q_out ({sck_s, si_s})
    );

    assign mode_ok = (transfer_mode_field == `SSFD_MODE_TXRX); // R1
    assign msb     = (bit_order_select == `SSFD_MSB_FIRST); // R1

    // internal clock runs mid-frame, or once both buffers are serviced
    assign int_run = mode_ok && !clk_src_ext && (in_frame_reg ||
                     (start_reg && !txe_reg && !rxf_reg && !rx_overrun_flag_reg)); // R10 R11

    ssfd_sckgen #(
        .HALF (SCK_HALF),
        .CW   (8)
    ) u_sckgen (
        .clk      (core_clk),
        .rst      (sys_rst | forced_stop_bit),
        .run      (int_run),
        .sck      (int_sck),
        .fall_pls (int_fall),
        .rise_pls (int_rise)
    );

    always @(posedge core_clk) begin
        if (sys_rst) begin
            sck_d_reg <= `SSFD_IDLE_LVL;
        end else begin
            sck_d_reg <= sck_s;
        end
    end

    assign ext_fall = sck_d_reg & ~sck_s;
    assign ext_rise = ~sck_d_reg & sck_s;
    assign fall_ev  = mode_ok && (clk_src_ext ? ext_fall : int_fall); // R4
    assign rise_ev  = mode_ok && (clk_src_ext ? ext_rise : int_rise); // R4

    // a new frame needs the start bit; mid-frame edges always count
    assign frame_start = fall_ev && !in_frame_reg && start_reg; // R8 R9
    assign frame_end   = rise_ev && in_frame_reg &&
                         (rise_cnt_reg == `SSFD_LAST_BIT); // R19

    assign shift_nx = msb ? {shift_reg[6:0], si_s} : {si_s, shift_reg[7:1]};

    assign txe_set = rise_ev && load_pend_reg; // R6
    assign ovr_set = frame_end && !rx_overrun_flag_reg && rxf_reg; // R16
    assign rxf_set = frame_end && !rx_overrun_flag_reg && !rxf_reg; // R7

    always @(posedge core_clk) begin
        if (sys_rst || forced_stop_bit) begin // R22
            start_reg     <= 1'b0;
            active_reg    <= 1'b0;
            sef_reg       <= 1'b0;
            txe_reg       <= `SSFD_TXE_INIT;
            rxf_reg       <= `SSFD_RXF_INIT;
            tx_underrun_flag_reg     <= 1'b0;
            rx_overrun_flag_reg     <= 1'b0;
            irq_reg       <= 1'b0;
            rd_data_reg   <= `SSFD_BUF_INIT;
            so_reg        <= `SSFD_IDLE_LVL;
            tx_buf_reg    <= `SSFD_BUF_INIT;
            rx_buf_reg    <= `SSFD_BUF_INIT;
            shift_reg     <= `SSFD_BUF_INIT;
            fall_cnt_reg  <= `SSFD_CNT_ZERO;
            rise_cnt_reg  <= `SSFD_CNT_ZERO;
            in_frame_reg  <= 1'b0;
            load_pend_reg <= 1'b0;
            rd_seen_reg   <= 1'b0;
        end else begin
            irq_reg <= 1'b0;

            if (start_set) begin
                start_reg <= 1'b1;
            end else if (start_clr) begin
                start_reg <= 1'b0;
            end

            // transmit buffer write; hardware set wins a tie
            if (tx_wr_stb) begin
                tx_buf_reg <= tx_wr_data;
            end
            if (txe_set) begin
                txe_reg       <= 1'b1; // R6
                load_pend_reg <= 1'b0;
            end else if (tx_wr_stb) begin
                txe_reg <= 1'b0; // R2
            end

            // receive buffer read
            if (rx_rd_stb) begin
                if (rx_overrun_flag_reg) begin
                    // overrun: old frame first, then shift register
                    rd_data_reg <= rd_seen_reg ? shift_reg : rx_buf_reg; // R18
                    rd_seen_reg <= 1'b1;
                end else begin
                    rd_data_reg <= rx_buf_reg;
                end
            end
            if (rxf_set) begin
                rxf_reg <= 1'b1; // R7
            end else if (rx_overrun_clr && rx_overrun_flag_reg) begin
                rxf_reg <= 1'b0; // R18
            end else if (rx_rd_stb && !rx_overrun_flag_reg) begin
                rxf_reg <= 1'b0; // R2
            end

            if (ovr_set) begin
                rx_overrun_flag_reg <= 1'b1; // R16
            end else if (rx_overrun_clr) begin
                rx_overrun_flag_reg   <= 1'b0;
                rd_seen_reg <= 1'b0;
            end

            // falling edge: frame start or next output bit
            if (frame_start) begin
                active_reg   <= 1'b1; // R3
                sef_reg      <= 1'b1; // R5
                in_frame_reg <= 1'b1;
                fall_cnt_reg <= `SSFD_CNT_ONE;
                rise_cnt_reg <= `SSFD_CNT_ZERO;
                if (txe_reg) begin
                    tx_underrun_flag_reg <= 1'b1; // R13
                    so_reg    <= `SSFD_IDLE_LVL; // R14
                end else begin
                    shift_reg     <= tx_buf_reg; // R8 R9
                    load_pend_reg <= 1'b1;
                    so_reg <= tx_underrun_flag_reg ? `SSFD_IDLE_LVL :
                              (msb ? tx_buf_reg[7] : tx_buf_reg[0]); // R4 R14
                end
            end else if (fall_ev && in_frame_reg) begin
                fall_cnt_reg <= fall_cnt_reg + `SSFD_CNT_ONE;
                if (fall_cnt_reg == `SSFD_LAST_BIT) begin
                    sef_reg <= 1'b0; // R5
                end
                so_reg <= tx_underrun_flag_reg ? `SSFD_IDLE_LVL :
                          (msb ? shift_reg[7] : shift_reg[0]); // R4 R14
            end

            // rising edge: sample serial in
            if (rise_ev && in_frame_reg) begin
                rise_cnt_reg <= rise_cnt_reg + `SSFD_CNT_ONE;
                if (!rx_overrun_flag_reg) begin
                    shift_reg <= shift_nx; // R4 R17
                end
            end

            if (frame_end) begin
                in_frame_reg <= 1'b0;
                if (rxf_set) begin
                    rx_buf_reg <= shift_nx; // R7
                end
                if (!rx_overrun_flag_reg) begin
                    irq_reg <= 1'b1; // R7 R13 R23
                end
                if (!start_reg) begin
                    active_reg <= 1'b0; // R20
                    so_reg     <= `SSFD_IDLE_LVL; // R20
                end
            end else if (!in_frame_reg && !start_reg && active_reg) begin
                // start cleared during auto wait: nothing left to finish
                active_reg <= 1'b0; // R20
                so_reg     <= `SSFD_IDLE_LVL;
            end
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            sck_oe_reg <= 1'b0;
        end else begin
            sck_oe_reg <= mode_ok && !clk_src_ext; // R1
        end
    end

    assign transfer_start_bit   = start_reg;
    assign transfer_active_flag = active_reg;
    assign shift_active_flag    = sef_reg;
    assign tx_buffer_empty_flag = txe_reg;
    assign rx_buffer_full_flag  = rxf_reg;
    assign tx_underrun_flag     = tx_underrun_flag_reg;
    assign rx_overrun_flag      = rx_overrun_flag_reg;
    assign serial_irq           = irq_reg;
    assign rx_rd_data           = rd_data_reg;
    assign sck_out              = int_sck;
    assign sck_oe               = sck_oe_reg;
    assign so_out               = so_reg;

endmodule // ssfd_serial

`default_nettype wire

/* File: bench/ssfd_serial_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module ssfd_serial_chk (
    input wire logic       core_clk,
    input wire logic       sys_rst,
    input wire logic       tx_wr_stb,
    input wire logic       forced_stop_bit,
    input wire logic       transfer_start_bit,
    input wire logic       transfer_active_flag,
    input wire logic       shift_active_flag,
    input wire logic       tx_buffer_empty_flag,
    input wire logic       rx_buffer_full_flag,
    input wire logic       tx_underrun_flag,
    input wire logic       rx_overrun_flag,
    input wire logic       serial_irq,
    input wire logic [7:0] rx_rd_data,
    input wire logic       sck_out,
    input wire logic       sck_oe,
    input wire logic       so_out
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    property p_wr;
        tx_wr_stb && !shift_active_flag && !forced_stop_bit
            |=> !tx_buffer_empty_flag;
    endproperty
    a_wr: assert property (p_wr) else $error("write kept empty");
    property p_full;
        $rose(rx_buffer_full_flag) |-> serial_irq;
    endproperty
    a_full: assert property (p_full) else $error("full without irq");
    property p_or;
        rx_overrun_flag && $past(rx_overrun_flag) |-> !serial_irq;
    endproperty
    a_or: assert property (p_or) else $error("irq in overrun");
    property p_uf;
        tx_underrun_flag |-> so_out;
    endproperty
    a_uf: assert property (p_uf) else $error("so low in underrun");
    property p_idle;
        !transfer_active_flag |-> so_out;
    endproperty
    a_idle: assert property (p_idle) else $error("so low idle");
    property p_so;
        sck_oe && transfer_active_flag && $past(transfer_active_flag)
            && $changed(so_out) |-> !$past(sck_out) && $past(sck_out, 2);
    endproperty
    a_so: assert property (p_so) else $error("so moved off fall");
    property p_go;
        sck_oe && $fell(sck_out) && !$past(shift_active_flag)
            |-> !$past(tx_buffer_empty_flag) && !$past(rx_buffer_full_flag);
    endproperty
    a_go: assert property (p_go) else $error("clock left wait");
    property p_ovr;
        $rose(rx_overrun_flag) |-> rx_buffer_full_flag && $stable(rx_rd_data);
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun state");
    property p_fs;
        forced_stop_bit |=> !transfer_start_bit && !transfer_active_flag
            && !shift_active_flag && tx_buffer_empty_flag
            && !rx_buffer_full_flag && !tx_underrun_flag
            && !rx_overrun_flag && rx_rd_data == 8'h00;
    endproperty
    a_fs: assert property (p_fs) else $error("stop left state");
    c_irq: cover property (serial_irq);
    c_ovr: cover property ($rose(rx_overrun_flag));
    c_uf: cover property ($rose(tx_underrun_flag));
endmodule // ssfd_serial_chk
bind ssfd_serial ssfd_serial_chk u_chk (
    .core_clk, .sys_rst, .tx_wr_stb, .forced_stop_bit, .transfer_start_bit,
    .transfer_active_flag, .shift_active_flag, .tx_buffer_empty_flag,
    .rx_buffer_full_flag, .tx_underrun_flag, .rx_overrun_flag,
    .serial_irq, .rx_rd_data, .sck_out, .sck_oe, .so_out
);
`default_nettype wire

/* File: bench/ssfd_peer.sv */
`timescale 1ns/1ns
`default_nettype none
module ssfd_peer (
    input  wire logic       ext,
    input  wire logic       sck_out,
    input  wire logic       so_out,
    output var  logic       sck_in,
    output var  logic       si_in,
    output var  logic [7:0] rxb
);
    logic [7:0] txs;
    logic [2:0] n;
    wire        lk = ext ? sck_in : sck_out;
    initial begin
        sck_in = 1'b1;
        si_in = 1'b1;
        rxb = 8'h00;
        txs = 8'h00;
        n = 3'h0;
    end
    task load(input logic [7:0] b);
        txs = b;
        n = 3'h0;
    endtask
    // clock stands high between frames
    task frame(input logic [7:0] b);
        load(b);
        repeat (8) begin
            #40 sck_in = 1'b0;
            #40 sck_in = 1'b1;
        end
        #200;
    endtask
    always @(negedge lk) begin
        si_in <= txs[7];
        txs <= {txs[6:0], 1'b0};
    end
    always @(posedge lk) begin
        rxb <= {rxb[6:0], so_out};
        n <= n + 3'h1;
        // released line shows the inverse once the last bit is sampled
        if (n == 3'h7)
            si_in <= #30 ~si_in;
    end
endmodule // ssfd_peer
`default_nettype wire

/* File: bench/ssfd_serial_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module ssfd_serial_tb;
    logic       core_clk, sys_rst, clk_src_ext, bit_order_select;
    logic [1:0] transfer_mode_field;
    logic [7:0] tx_wr_data, irqs;
    logic [5:0] stb;
    int         num_errors, comparisons, i;
    wire transfer_start_bit, transfer_active_flag, shift_active_flag;
    wire tx_buffer_empty_flag, rx_buffer_full_flag, tx_underrun_flag;
    wire rx_overrun_flag, serial_irq, sck_out, sck_oe, so_out, sck_in, si_in;
    wire [7:0] rx_rd_data, peer_rx;
    ssfd_serial dut (
        .core_clk, .sys_rst, .transfer_mode_field, .clk_src_ext,
        .bit_order_select, .start_set(stb[0]), .start_clr(stb[1]),
        .forced_stop_bit(stb[5]), .tx_wr_stb(stb[2]), .tx_wr_data,
        .rx_rd_stb(stb[3]), .rx_overrun_clr(stb[4]), .sck_in,
        .si_in, .transfer_start_bit, .transfer_active_flag,
        .shift_active_flag, .tx_buffer_empty_flag, .rx_buffer_full_flag,
        .tx_underrun_flag, .rx_overrun_flag, .serial_irq, .rx_rd_data,
        .sck_out, .sck_oe, .so_out
    );
    ssfd_peer peer (.ext(clk_src_ext), .sck_out, .so_out, .sck_in, .si_in,
                    .rxb(peer_rx));
    always @(posedge core_clk)
        if (sys_rst)
            irqs <= 8'h00;
        else if (serial_irq === 1'b1)
            irqs <= irqs + 8'h01;
    task conclude;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task pl(input logic [5:0] m);
        @(negedge core_clk);
        stb = m;
        @(negedge core_clk);
        stb = 6'h00;
    endtask
    task wr(input logic [7:0] b);
        tx_wr_data = b;
        pl(6'h04);
    endtask
    task rd(input logic [7:0] e);
        pl(6'h08);
        chk("rx_rd_data", e, rx_rd_data);
    endtask
    task wn(input logic [7:0] k);
        int j;
        for (j = 0; j < 3000 && irqs !== k; j++)
            @(negedge core_clk);
        chk("irq_count", k, irqs);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        #200000;
        num_errors++;
        conclude();
    end
    initial begin
        sys_rst = 1'b1;
        stb = 6'h00;
        transfer_mode_field = 2'b00;
        clk_src_ext = 1'b0;
        bit_order_select = 1'b1;
        tx_wr_data = 8'h00;
        num_errors = 0;
        comparisons = 0;
        repeat (12) @(negedge core_clk);
        sys_rst = 1'b0;
        chk("reset", 8'h05, {5'h0, so_out, rx_buffer_full_flag,
            tx_buffer_empty_flag});
        wr(8'ha5);
        chk("empty", 8'h00, {7'h0, tx_buffer_empty_flag});
        peer.load(8'h3c);
        pl(6'h01);
        repeat (20) @(negedge core_clk);
        chk("idle", 8'h01, {5'h0, sck_oe, transfer_active_flag, sck_out});
        transfer_mode_field = 2'b10;
        wn(8'h01);
        chk("peer_rx", 8'ha5, peer_rx);
        chk("flags", 8'h03, {6'h0, rx_buffer_full_flag, tx_buffer_empty_flag});
        wr(8'h5a);
        repeat (40) @(negedge core_clk);
        chk("sck_wait", 8'h03, {6'h0, sck_oe, sck_out});
        peer.load(8'hc3);
        rd(8'h3c);
        for (i = 0; i < 20 && shift_active_flag !== 1'b1; i++)
            @(negedge core_clk);
        chk("resume", 8'h01, {7'h0, shift_active_flag});
        pl(6'h02);
        wn(8'h02);
        chk("peer_rx", 8'h5a, peer_rx);
        chk("stopped", 8'h01, {6'h0, transfer_active_flag, so_out});
        rd(8'hc3);
        bit_order_select = 1'b0;
        wr(8'h12);
        peer.load(8'h34);
        pl(6'h01);
        wn(8'h03);
        chk("peer_rx", 8'h48, peer_rx);
        rd(8'h2c);
        pl(6'h20);
        chk("stop", 8'h01, {6'h0, transfer_start_bit, tx_buffer_empty_flag});
        clk_src_ext = 1'b1;
        bit_order_select = 1'b1;
        wr(8'he7);
        pl(6'h01);
        peer.frame(8'h99);
        wn(8'h04);
        chk("peer_rx", 8'he7, peer_rx);
        peer.frame(8'h11);
        wn(8'h05);
        chk("errors", 8'h03, {6'h0, tx_underrun_flag, rx_overrun_flag});
        chk("peer_rx", 8'hff, peer_rx);
        peer.frame(8'h22);
        chk("irq_count", 8'h05, irqs);
        pl(6'h02);
        peer.frame(8'h22);
        chk("irq_count", 8'h05, irqs);
        chk("active", 8'h00, {7'h0, transfer_active_flag});
        rd(8'h99);
        rd(8'h11);
        pl(6'h10);
        chk("full", 8'h00, {7'h0, rx_buffer_full_flag});
        pl(6'h20);
        conclude();
    end
endmodule // ssfd_serial_tb
`default_nettype wire
